// >>> bgd_pkg.sv
// Constants, register map and types for the bridge gate control block.
// Assumes a 125 MHz pclk; all times except the 50 ns dead-time step are turned into cycle counts here.
package bgd_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_NS      = 8;
  localparam int DT_STEP_NS  = 50;
  localparam int BS_CHG_NS   = 20000;
  localparam int BS_CHG_CYC  = BS_CHG_NS / CLK_NS;
  localparam int RES_NS      = 1000;
  localparam int RES_CYC     = (RES_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_NS    = 10000;
  localparam int SLEEP_CYC   = (SLEEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int BRK_NS      = 20000;
  localparam int BRK_CYC     = (BRK_NS + CLK_NS - 1) / CLK_NS;
  localparam int PUMP_NS     = 3000000;
  localparam int PUMP_CYC    = PUMP_NS / CLK_NS;
  localparam logic [5:0] DT_MIN_N = 6'h02;

  // ==========================================================
  // Register map
  typedef logic [7:0] bgd_addr_t;
  localparam bgd_addr_t OFS_TIMING  = 8'h00;
  localparam bgd_addr_t OFS_STARTUP = 8'h04;
  localparam bgd_addr_t OFS_RUN     = 8'h08;
  localparam bgd_addr_t OFS_DRIVE   = 8'h0c;
  localparam bgd_addr_t OFS_STATUS  = 8'h10;
  localparam bgd_addr_t OFS_MASK    = 8'h14;
  localparam bgd_addr_t OFS_DIAG    = 8'h18;
  localparam bgd_addr_t OFS_STATE   = 8'h1c;
  localparam int IDS_BIT   = 8;
  localparam int RUN_BIT   = 0;
  localparam int BRK_BIT   = 2;
  localparam int FF_BIT    = 15;
  localparam int NEV       = 6;
  localparam logic [5:0] DT_RST = 6'h00;

  // ==========================================================
  // Per-phase driver state
  typedef enum logic [4:0] {
    PH_OFF  = 5'h01,
    PH_DEAD = 5'h02,
    PH_LOW  = 5'h04,
    PH_HIGH = 5'h08,
    PH_CHG  = 5'h10
  } bgd_ph_state_t;
endpackage

// >>> bgd_phase_if.sv
// Signals between the controller and one phase driver.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
`default_nettype none
interface bgd_phase_if;
  logic       want_hi;
  logic       want_lo;
  logic       bs_on_ok;
  logic       bs_low;
  logic       force_off;
  logic [5:0] dead_n;
  logic       gl;
  logic       gh;
  logic       bs_fault;
  modport ctl (output want_hi, want_lo, bs_on_ok, bs_low, force_off, dead_n,
               input gl, gh, bs_fault);
  modport drv (input want_hi, want_lo, bs_on_ok, bs_low, force_off, dead_n,
               output gl, gh, bs_fault);
endinterface
`default_nettype wire

// >>> bgd_phase.sv
// One bridge phase: dead time, bootstrap charge management, gate flops.
// Assumes want_hi and want_lo never both high and synchronised inputs.
`timescale 1ns/1ps
`default_nettype none
module bgd_phase (
  input  wire logic  pclk,
  input  wire logic  presetn,
  bgd_phase_if.drv   bus
);
  import bgd_pkg::*;

  localparam int CHG_LAST = BS_CHG_CYC - 1;
  localparam int MIN_GAP  = (2 * DT_STEP_NS + CLK_NS - 1) / CLK_NS;

  bgd_ph_state_t st_q;
  logic        chg_q;
  logic [5:0]  acc_q;
  logic [5:0]  ticks_q;
  logic [11:0] chg_cnt_q;
  logic        gl_q;
  logic        gh_q;
  logic        flt_q;
  logic [5:0]  dn;
  logic [5:0]  acc_nx;
  logic        tick;
  logic        dead_done;
  logic        any_want;
  logic        chg_fail;

  // ==========================================================
  // Dead time
  assign dn        = (bus.dead_n < DT_MIN_N) ? DT_MIN_N : bus.dead_n;
  assign acc_nx    = acc_q + 6'(CLK_NS);
  assign tick      = acc_nx >= 6'(DT_STEP_NS);
  assign dead_done = tick && ({1'b0, ticks_q} + 7'h01 >= {1'b0, dn});
  assign any_want  = bus.want_hi || bus.want_lo;
  assign chg_fail  = (chg_cnt_q == 12'(CHG_LAST)) && !bus.bs_on_ok;

  // Fractional 8 ns steps give an exact 50 ns average tick rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q   <= 6'h00;
      ticks_q <= 6'h00;
    end else if (st_q == PH_DEAD) begin
      acc_q   <= tick ? acc_nx - 6'(DT_STEP_NS) : acc_nx;
      ticks_q <= tick ? ticks_q + 6'h01 : ticks_q;
    end else begin
      acc_q   <= 6'h00;
      ticks_q <= 6'h00;
    end
  end

  // ==========================================================
  // Sequencing: every turn-on passes through the dead state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= PH_OFF;
      chg_q    <= 1'b0;
    end else if (bus.force_off) begin
      st_q <= PH_OFF;
    end else begin
      unique case (st_q)
        PH_OFF: if (any_want) begin
          st_q     <= PH_DEAD;
          chg_q    <= 1'b0;
        end
        PH_DEAD: begin
          if (!any_want) st_q <= PH_OFF;
          else if (dead_done) begin
            if (chg_q || (bus.want_hi && !bus.bs_on_ok)) st_q <= PH_CHG;
            else if (bus.want_hi) st_q <= PH_HIGH;
            else st_q <= PH_LOW;
          end
        end
        PH_HIGH: if (!bus.want_hi || bus.bs_low) begin
          st_q     <= PH_DEAD;
          chg_q    <= bus.want_hi;
        end
        PH_LOW: if (!bus.want_lo) begin
          st_q     <= PH_DEAD;
        end
        PH_CHG: begin
          if (bus.bs_on_ok || !bus.want_hi) begin
            st_q     <= PH_DEAD;
            chg_q    <= 1'b0;
          end else if (chg_fail) st_q <= PH_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) chg_cnt_q <= 12'h000;
    else if (st_q == PH_CHG) chg_cnt_q <= chg_cnt_q + 12'h001;
    else chg_cnt_q <= 12'h000;
  end

  // ==========================================================
  // Gate flops, active high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gl_q  <= 1'b0;
      gh_q  <= 1'b0;
      flt_q <= 1'b0;
    end else begin
      gl_q  <= !bus.force_off && (st_q == PH_LOW || st_q == PH_CHG);
      gh_q  <= !bus.force_off && st_q == PH_HIGH;
      flt_q <= !bus.force_off && st_q == PH_CHG && bus.want_hi && chg_fail;
    end
  end
  assign bus.gl       = gl_q;
  assign bus.gh       = gh_q;
  assign bus.bs_fault = flt_q;

  // ==========================================================
  // Checks
  logic [9:0] gap_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_q <= 10'h3ff;
    else if (gl_q || gh_q) gap_q <= 10'h000;
    else if (gap_q != 10'h3ff) gap_q <= gap_q + 10'h001;
  end

  a_no_overlap: assert property (@(posedge pclk) disable iff (!presetn)
    !(gl_q && gh_q)) else $error("both gates of a phase on");
  a_dead_min: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(gl_q) || $rose(gh_q)) |-> gap_q >= 10'(MIN_GAP - 1))
    else $error("dead gap below minimum");
  a_dead_len: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(gl_q) || $rose(gh_q)) |->
    ((16'(dn) * 16'(DT_STEP_NS)) <= (16'(gap_q) + 16'h0001) * 16'(CLK_NS)))
    else $error("dead gap shorter than programmed");
  a_hi_needs_bs: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(gh_q) |-> $past(bus.bs_on_ok, 2)) else $error("high side on without charge");
  a_recharge: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == PH_HIGH && bus.bs_low && bus.want_hi && !bus.force_off)
    |=> (st_q == PH_DEAD && chg_q) ##[1:400] st_q == PH_CHG)
    else $error("no recharge after bootstrap droop");
  a_chg_fault: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == PH_CHG && chg_fail && bus.want_hi && !bus.force_off) |=> flt_q && st_q == PH_OFF)
    else $error("bootstrap fault not raised");
  c_recharge: cover property (@(posedge pclk) disable iff (!presetn)
    st_q == PH_HIGH ##1 st_q == PH_DEAD ##[1:400] st_q == PH_CHG);
  c_fault: cover property (@(posedge pclk) disable iff (!presetn) flt_q);
endmodule // bgd_phase
`default_nettype wire

// >>> bgd_top.sv
// Bridge gate control: APB registers, sleep/reset pin, brake and chopping.
// Assumes pins are asynchronous to pclk and a 125 MHz pclk.
//
// How it works
// - Dead time for all phases is field value times 50 ns.
// - Field values 0, 1 and 2 give the 100 ns minimum.
// - After any gate turns off, wait dead time before complementary turn-on.
// - High side waits for bootstrap charge; low side recharges it first.
// - While high side is on, bootstrap droop starts a recharge cycle.
// - Bootstrap that cannot be charged raises a bootstrap fault.
// - Reset pin low past the sleep time stops the pump and sleeps.
// - Entering sleep clears latched faults and their flags.
// - Leaving sleep keeps every gate off until the pump settles.
// - A short reset pulse clears latched short faults and the fault register.
// - A high gate output turns its transistor on, low turns it off.
// - Start-up current limit acts only when the disable bit is 0.
// - During start-up the speed input is ignored except for braking.
// - Speed input held low past brake time brakes, only while running.
// - Brake turns all low sides on and all high sides off.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bgd_top #(
  parameter int PUMP_SETTLE_CYC = bgd_pkg::PUMP_CYC
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire bgd_pkg::bgd_addr_t paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  input  wire logic             sleep_reset_n,
  input  wire logic             speed_mod_in,
  input  wire logic             short_fault,
  input  wire logic [2:0]       bs_above_on,
  input  wire logic [2:0]       bs_below_off,
  input  wire logic             startup_active,
  output var  logic [2:0]       low_side_gate_out,
  output var  logic [2:0]       high_side_gate_out,
  output var  logic             pump_enable,
  output var  logic             current_limit_enable,
  output var  logic             irq
);
  import bgd_pkg::*;

  // ==========================================================
  // Pin synchronisers
  localparam logic [8:0] SYNC_RST = 9'h180;
  logic [8:0] s1_q;
  logic [8:0] s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
    end else begin
      s1_q <= {sleep_reset_n, speed_mod_in, short_fault, bs_above_on, bs_below_off};
      s2_q <= s1_q;
    end
  end
  logic       rst_pin;
  logic       mod_pin;
  logic       short_s;
  logic [2:0] bs_on_s;
  logic [2:0] bs_low_s;
  assign {rst_pin, mod_pin, short_s, bs_on_s, bs_low_s} = s2_q;

  // ==========================================================
  // Registers
  logic [5:0]     dt_q;
  logic           ids_q;
  logic           run_q;
  logic           brk_bit_q;
  logic [5:0]     drv_q;
  logic [NEV-1:0] stat_q;
  logic [NEV-1:0] mask_q;
  logic [3:0]     diag_q;
  logic           wr_acc;
  logic           rd_acc;
  logic           known;
  logic [31:0]    rdata;

  function automatic logic hit(input bgd_addr_t a, input bgd_addr_t ofs);
    hit = (a == ofs);
  endfunction

  assign wr_acc = psel && penable && pready && pwrite && !pslverr;
  assign rd_acc = psel && penable && pready && !pwrite && hit(paddr, OFS_STATUS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dt_q      <= DT_RST;
      ids_q     <= 1'b0;
      run_q     <= 1'b0;
      brk_bit_q <= 1'b0;
      drv_q     <= 6'h00;
      mask_q    <= '0;
    end else if (wr_acc) begin
      if (hit(paddr, OFS_TIMING)) dt_q <= pwdata[5:0];
      if (hit(paddr, OFS_STARTUP)) ids_q <= pwdata[IDS_BIT];
      if (hit(paddr, OFS_RUN)) begin
        run_q     <= pwdata[RUN_BIT];
        brk_bit_q <= pwdata[BRK_BIT];
      end
      if (hit(paddr, OFS_DRIVE)) drv_q <= pwdata[5:0];
      if (hit(paddr, OFS_MASK)) mask_q <= pwdata[NEV-1:0];
    end
  end

  logic [2:0] gl_w;
  logic [2:0] gh_w;
  logic       sleep_q;
  logic       pump_wait_q;
  logic       brake_q;

  always_comb begin
    known = 1'b1;
    rdata = 32'h0000_0000;
    unique case (paddr)
      OFS_TIMING:  rdata[5:0] = dt_q;
      OFS_STARTUP: rdata[IDS_BIT] = ids_q;
      OFS_RUN:     rdata = {29'h0, brk_bit_q, 1'b0, run_q};
      OFS_DRIVE:   rdata[5:0] = drv_q;
      OFS_STATUS:  rdata[NEV-1:0] = stat_q;
      OFS_MASK:    rdata[NEV-1:0] = mask_q;
      OFS_DIAG:    rdata = {16'h0, |diag_q, 11'h0, diag_q};
      OFS_STATE:   rdata = {23'h0, brake_q, pump_wait_q, sleep_q, gh_w, gl_w};
      default:     known = 1'b0;
    endcase
  end

  // No wait states: data is captured at setup so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !known;
      if (psel && !penable && !pwrite) prdata <= rdata;
    end
  end

  // ==========================================================
  // Sleep and fault clearing from the reset pin
  logic [11:0] rlow_q;
  logic [19:0] pump_cnt_q;
  logic        clr_pulse;
  logic        sleep_in;
  logic        wake_done;
  assign clr_pulse = !rst_pin && rlow_q == 12'(RES_CYC - 1);
  assign sleep_in  = !rst_pin && rlow_q == 12'(SLEEP_CYC - 1);
  assign wake_done = pump_wait_q && pump_cnt_q == 20'(PUMP_SETTLE_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rlow_q <= 12'h000;
    else if (rst_pin) rlow_q <= 12'h000;
    else if (rlow_q != 12'(SLEEP_CYC)) rlow_q <= rlow_q + 12'h001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q     <= 1'b0;
      pump_enable <= 1'b1;
      pump_wait_q <= 1'b0;
      pump_cnt_q  <= 20'h00000;
    end else begin
      if (sleep_in) begin
        sleep_q     <= 1'b1;
        pump_enable <= 1'b0;
      end else if (sleep_q && rst_pin) begin
        sleep_q     <= 1'b0;
        pump_enable <= 1'b1;
        pump_wait_q <= 1'b1;
      end else if (wake_done) pump_wait_q <= 1'b0;
      pump_cnt_q <= pump_wait_q ? pump_cnt_q + 20'h00001 : 20'h00000;
    end
  end

  // ==========================================================
  // Faults and interrupt; a new event beats a clear in the same cycle
  logic       short_q;
  logic [2:0] bsf_w;
  logic [3:0] new_flt;
  logic       clr_all;
  assign new_flt = {short_s, bsf_w};
  assign clr_all = clr_pulse || sleep_in;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_q <= 1'b0;
      diag_q  <= 4'h0;
    end else begin
      short_q <= short_s || (short_q && !clr_all);
      diag_q  <= new_flt | (clr_all ? 4'h0 : diag_q);
    end
  end

  logic [NEV-1:0] ev;
  assign ev = {wake_done, sleep_in, short_s && !short_q, bsf_w};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
      irq    <= 1'b0;
    end else begin
      // Only bits actually returned to software are cleared
      stat_q <= ev | (stat_q & ~(rd_acc ? prdata[NEV-1:0] : '0));
      irq    <= |(stat_q & mask_q);
    end
  end

  // ==========================================================
  // Brake, chopping and start-up current limit
  logic [11:0] mlow_q;
  logic        mod_brake;
  logic        chop;
  assign mod_brake = mlow_q == 12'(BRK_CYC);
  assign chop      = !mod_pin && !startup_active && !brake_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mlow_q <= 12'h000;
    else if (mod_pin) mlow_q <= 12'h000;
    else if (!mod_brake) mlow_q <= mlow_q + 12'h001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_q              <= 1'b0;
      current_limit_enable <= 1'b0;
    end else begin
      brake_q              <= run_q && (brk_bit_q || mod_brake);
      current_limit_enable <= !startup_active || !ids_q;
    end
  end

  // ==========================================================
  // Phase drivers
  bgd_phase_if pif[3] ();
  logic force_off;
  assign force_off = sleep_q || pump_wait_q || short_q;

  for (genvar i = 0; i < 3; i++) begin : g_ph
    assign pif[i].want_hi   = run_q && !brake_q && drv_q[i] && !chop;
    assign pif[i].want_lo   = run_q && (brake_q || drv_q[3 + i]
                                        || (drv_q[i] && chop));
    assign pif[i].bs_on_ok  = bs_on_s[i];
    assign pif[i].bs_low    = bs_low_s[i];
    assign pif[i].force_off = force_off;
    assign pif[i].dead_n    = dt_q;
    assign gl_w[i]          = pif[i].gl;
    assign gh_w[i]          = pif[i].gh;
    assign bsf_w[i]         = pif[i].bs_fault;
    bgd_phase u_ph (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (pif[i])
    );
  end

  assign low_side_gate_out  = gl_w;
  assign high_side_gate_out = gh_w;

  // ==========================================================
  // Checks
  a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_in |=> sleep_q && !pump_enable) else $error("sleep not entered");
  a_sleep_clears: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_in |=> (diag_q & ~$past(new_flt)) == 4'h0) else $error("faults kept in sleep");
  a_wake_hold: assert property (@(posedge pclk) disable iff (!presetn)
    force_off |=> gl_w == 3'h0 && gh_w == 3'h0) else $error("gate on while held");
  a_clear_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    clr_pulse && !short_s |=> !short_q) else $error("short latch not cleared");
  a_ids_gate: assert property (@(posedge pclk) disable iff (!presetn)
    startup_active && ids_q && $stable(ids_q) && $past(startup_active)
    |-> !current_limit_enable) else $error("start-up limit not disabled");
  a_mod_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    startup_active |-> !chop) else $error("speed input chops during start-up");
  a_brake_run: assert property (@(posedge pclk) disable iff (!presetn)
    brake_q |-> $past(run_q)) else $error("brake without run");
  a_brake_gates: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(brake_q) |-> ##2 gh_w == 3'h0) else $error("high side on in brake");
  c_brake: cover property (@(posedge pclk) disable iff (!presetn)
    brake_q && gl_w == 3'h7);
  c_sleep: cover property (@(posedge pclk) disable iff (!presetn) $fell(sleep_q));
  c_clear: cover property (@(posedge pclk) disable iff (!presetn) clr_pulse);
endmodule // bgd_top
`default_nettype wire

// >>> bgd_bridge_model.sv
// Behavioural power bridge: one bootstrap capacitor level per phase.
// Assumes gate levels from the block under test on the same pclk.
`timescale 1ns/1ps
`default_nettype none
module bgd_bridge_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] gl,
  input  wire logic [2:0] gh,
  input  wire logic       no_chg,
  output var  logic [2:0] above_on,
  output var  logic [2:0] below_off
);
  logic [5:0] lvl_q [3];
  logic [2:0] sub_q;
  // ==========================================================
  // Capacitor charge
  // Low side on charges, high side on drains slowly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_q <= 3'h0;
      for (int k = 0; k < 3; k++) lvl_q[k] <= 6'h3f;
    end else begin
      sub_q <= sub_q + 3'h1;
      for (int k = 0; k < 3; k++) begin
        // Held flat models a capacitor that cannot charge
        if (no_chg) lvl_q[k] <= 6'h00;
        else if (gl[k]) lvl_q[k] <= (lvl_q[k] < 6'h38) ? lvl_q[k] + 6'h08 : 6'h3f;
        else if (gh[k] && sub_q == 3'h0 && lvl_q[k] != 6'h00) lvl_q[k] <= lvl_q[k] - 6'h01;
      end
    end
  end
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      above_on[k]  = lvl_q[k] >= 6'h30;
      below_off[k] = lvl_q[k] < 6'h10;
    end
  end
endmodule // bgd_bridge_model
`default_nettype wire

// >>> bridge_gate_control_dead_time_tb_top.sv
// Self-checking bench for the bridge gate control block.
// Assumes bgd_pkg, bgd_top and bgd_bridge_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module bridge_gate_control_dead_time_tb_top;
  import bgd_pkg::*;
  typedef struct {logic [5:0] dt; logic [31:0] dv; int i; int n;} bgd_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, irq, s;
  logic sleep_reset_n, speed_mod_in, short_fault, startup_active, no_chg;
  logic pump_enable, cle;
  bgd_addr_t   paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  ab, bl, lo, hi;
  logic [5:0]  g;
  int          miscompares, checks, c, t;
  bgd_row_t    rows [6] = '{'{6'h00, 32'h01, 3, 2}, '{6'h01, 32'h08, 0, 2},
    '{6'h02, 32'h02, 4, 2}, '{6'h03, 32'h10, 1, 3}, '{6'h18, 32'h04, 5, 24},
    '{6'h3f, 32'h20, 2, 63}};
  assign g = {hi, lo};
  bgd_top #(.PUMP_SETTLE_CYC(50)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_reset_n(sleep_reset_n),
    .speed_mod_in(speed_mod_in), .short_fault(short_fault), .bs_above_on(ab),
    .bs_below_off(bl), .startup_active(startup_active), .low_side_gate_out(lo),
    .high_side_gate_out(hi), .pump_enable(pump_enable), .current_limit_enable(cle),
    .irq(irq));
  bgd_bridge_model bm_u (.pclk(pclk), .presetn(presetn), .gl(lo), .gh(hi),
    .no_chg(no_chg), .above_on(ab), .below_off(bl));
  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input bgd_addr_t a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wt(input int i, input int mx);
    s = 1'b0;
    for (int k = 0; k < mx && !s; k++) begin
      @(posedge pclk);
      s = (g[i] === 1'b1);
    end
  endtask
  task test_done();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Shoot-through never allowed on any phase
  always @(posedge pclk) if (presetn === 1'b1) chk({29'h0, lo & hi}, 32'h0);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #(8 * 40000);
    miscompares++;
    test_done();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, short_fault, startup_active, no_chg} = 6'h00;
    {sleep_reset_n, speed_mod_in, presetn} = 3'b110;
    paddr = 8'h00; pwdata = 32'h0; miscompares = 0; checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({pump_enable, irq, g}, {2'b10, 6'h00});
    apb(0, OFS_TIMING, 0); chk(rd, {26'h0, DT_RST});
    apb(0, 8'h40, 0); chk(er, 1'b1);
    apb(0, OFS_STATUS, 0);
    apb(1, OFS_RUN, 32'h1);
    $display("test reset done");
    foreach (rows[r]) begin
      t = (rows[r].n * DT_STEP_NS + CLK_NS - 1) / CLK_NS;
      apb(1, OFS_TIMING, {26'h0, rows[r].dt});
      apb(1, OFS_DRIVE, rows[r].dv);
      for (c = 0; g[rows[r].i] !== 1'b1 && c < 1000; c++) @(posedge pclk);
      chk(c >= t && c <= t + 7, 1'b1);
    end
    $display("test dead time done");
    // Short dead time again so the later waits stay brief
    apb(1, OFS_DRIVE, 0); apb(1, OFS_TIMING, 0); apb(1, OFS_RUN, 32'h5);
    repeat (300) @(posedge pclk); chk(g, 6'h07);
    apb(1, OFS_RUN, 32'h1); speed_mod_in <= 1'b0;
    repeat (2000) @(posedge pclk); chk(lo, 3'h0);
    repeat (900) @(posedge pclk); chk(g, 6'h07);
    speed_mod_in <= 1'b1;
    $display("test brake done");
    startup_active <= 1'b1; apb(1, OFS_STARTUP, 32'h100);
    repeat (4) @(posedge pclk); chk(cle, 1'b0);
    apb(1, OFS_STARTUP, 0); repeat (4) @(posedge pclk); chk(cle, 1'b1);
    apb(1, OFS_DRIVE, 32'h1); wt(3, 300); speed_mod_in <= 1'b0;
    repeat (50) @(posedge pclk); chk(hi[0], 1'b1);
    speed_mod_in <= 1'b1; startup_active <= 1'b0; // Speed input high again, as normal running chops while it is low
    $display("test start-up done");
    apb(1, OFS_DRIVE, 0); no_chg <= 1'b1;
    repeat (4) @(posedge pclk); no_chg <= 1'b0;
    apb(1, OFS_DRIVE, 32'h1);
    wt(0, 200); chk(s, 1'b1); wt(3, 300); chk(s, 1'b1);
    wt(0, 1000); chk(s, 1'b1);
    apb(1, OFS_MASK, 32'h1); apb(0, OFS_STATUS, 0); no_chg <= 1'b1;
    for (c = 0; irq !== 1'b1 && c < 4000; c++) @(posedge pclk);
    chk(irq, 1'b1); apb(0, OFS_STATUS, 0); chk(rd[0], 1'b1);
    repeat (3) @(posedge pclk); chk(irq, 1'b0);
    no_chg <= 1'b0;
    $display("test bootstrap done");
    wt(3, 3000); short_fault <= 1'b1; repeat (6) @(posedge pclk);
    chk(g, 6'h00); short_fault <= 1'b0;
    apb(0, OFS_DIAG, 0); chk(rd[3], 1'b1);
    sleep_reset_n <= 1'b0; repeat (200) @(posedge pclk); sleep_reset_n <= 1'b1;
    repeat (10) @(posedge pclk); apb(0, OFS_DIAG, 0); chk(rd, 32'h0);
    wt(3, 300); chk(s, 1'b1);
    short_fault <= 1'b1; repeat (6) @(posedge pclk); short_fault <= 1'b0;
    sleep_reset_n <= 1'b0; repeat (1400) @(posedge pclk); chk(pump_enable, 1'b0);
    apb(0, OFS_DIAG, 0); chk(rd, 32'h0);
    sleep_reset_n <= 1'b1; repeat (40) @(posedge pclk); chk(g, 6'h00);
    wt(3, 300); chk(s, 1'b1);
    apb(0, OFS_STATUS, 0); chk(rd, 32'h38);
    apb(0, OFS_STATE, 0); chk(rd, 32'h08);
    $display("test sleep done");
    test_done();
  end
endmodule // bridge_gate_control_dead_time_tb_top
`default_nettype wire
